// file: include/watchdog_pkg.sv
package watchdog_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 4;

	// register indices on the plain register port
	localparam logic [3:0] OFS_CTRL_STATUS_FIRST  = 4'h0;
	localparam logic [3:0] OFS_CTRL_STATUS_SECOND = 4'h1;
	localparam logic [3:0] OFS_UP_COUNTER         = 4'h2;
	localparam logic [3:0] OFS_CLOCK_SELECT       = 4'h3;
	localparam logic [3:0] OFS_IRQ_STATUS         = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK           = 4'h5;

	// first control/status register fields
	localparam int FIRST_RUN_BIT       = 0;
	localparam int FIRST_RUN_INHIBIT   = 1;
	localparam int FIRST_WRITE_ENABLE  = 2;
	localparam int FIRST_OVERFLOW_FLAG = 3;

	// second control/status register fields
	localparam int SECOND_MODE_SELECT  = 0;
	localparam int SECOND_MODE_INHIBIT = 1;
	localparam int SECOND_INT_ENABLE   = 2;

	// interrupt status and mask fields
	localparam int IRQ_INTERVAL = 0;
	localparam int IRQ_WD_RESET = 1;
	localparam int IRQ_W        = 2;

	// reset values, counter maximum and mode codes
	localparam logic [7:0] COUNTER_RESET   = 8'h00;
	localparam logic [7:0] COUNTER_MAX     = 8'hFF;
	localparam logic [2:0] CLKSEL_RESET    = 3'h7;
	localparam logic       MODE_WATCHDOG   = 1'b0;
	localparam logic       MODE_INTERVAL   = 1'b1;
	localparam logic [1:0] IRQ_MASK_RESET  = 2'h0;

	// prescaler: select code k divides the system clock by 2**(k+6); code 7 gives 8,192
	localparam int CLKSEL_W       = 3;
	localparam int DIV_STEPS      = 8;
	localparam int DIV_MIN_LOG2   = 6;
	localparam int PRESCALE_W     = 13;

	// timing
	localparam longint SYS_CLK_HZ       = 100_000_000;
	localparam longint OSC_CLK_HZ       = 100_000_000;
	localparam longint RESET_OSC_CYCLES = 512;
	localparam int     RESET_CLK_CYCLES =
		int'((RESET_OSC_CYCLES * SYS_CLK_HZ + OSC_CLK_HZ - 1) / OSC_CLK_HZ);
	localparam int     RST_CNT_W        = 16;
	localparam logic [15:0] RESET_LOAD  = 16'(RESET_CLK_CYCLES - 1);

endpackage

// file: include/prescale_if.sv
`timescale 1ns/1ns
interface prescale_if;
	logic [2:0] clk_sel;
	logic       tick;
	modport ctrl (output clk_sel, input tick);
	modport presc (input clk_sel, output tick);
endinterface

// file: logic/watchdog_prescaler.sv
`timescale 1ns/1ns
module watchdog_prescaler (
	input  wire logic clk,
	input  wire logic srst,
	prescale_if.presc ps
);

	typedef struct packed {
		logic [watchdog_pkg::PRESCALE_W-1:0] count;
		logic                                tick;
	} presc_state_type;

	presc_state_type state_reg;
	presc_state_type state_next;
	logic [watchdog_pkg::DIV_STEPS-1:0] tap;

	// one tap per divide step: all low bits of the free counter set
	genvar g;
	generate
		for (g = 0; g < watchdog_pkg::DIV_STEPS; g++) begin : g_tap
			assign tap[g] = &state_reg.count[g + watchdog_pkg::DIV_MIN_LOG2 - 1:0];
		end
	endgenerate

	always_comb begin
		state_next       = state_reg;
		state_next.count = state_reg.count + 13'h0001;
		state_next.tick  = tap[ps.clk_sel];
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ps.tick = state_reg.tick;

endmodule // watchdog_prescaler

// file: logic/watchdog_interval_timer.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module watchdog_interval_timer (
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            irq,
	output logic            wdt_reset_out
);

	typedef struct packed {
		logic [7:0]  count;
		logic        run;
		logic        write_en;
		logic        ovf_flag;
		logic        mode;
		logic        mode_armed;
		logic        int_en;
		logic [2:0]  clk_sel;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic        rst_active;
		logic [15:0] rst_cnt;
		logic [7:0]  rdata;
		logic        irq;
	} wdt_state_type;

	wdt_state_type s_reg;
	wdt_state_type s_next;
	logic          wr_first;
	logic          wr_second;
	logic          wr_count;
	logic          count_load;
	logic          tick;
	logic          ovf;
	logic          wd_ovf;
	logic          it_ovf;

	prescale_if ps ();

	watchdog_prescaler u_prescaler (
		.clk  (clk),
		.srst (srst),
		.ps   (ps)
	);

	assign ps.clk_sel = s_reg.clk_sel;
	assign tick       = ps.tick;
	assign wr_first   = reg_wr && (reg_addr == watchdog_pkg::OFS_CTRL_STATUS_FIRST);
	assign wr_second  = reg_wr && (reg_addr == watchdog_pkg::OFS_CTRL_STATUS_SECOND);
	assign wr_count   = reg_wr && (reg_addr == watchdog_pkg::OFS_UP_COUNTER);
	assign count_load = wr_count && s_reg.write_en;
	// a software load in the same cycle as the last tick wins, so no overflow
	assign ovf    = tick && s_reg.run && (s_reg.count == watchdog_pkg::COUNTER_MAX)
		&& !count_load;
	assign wd_ovf = ovf && (s_reg.mode == watchdog_pkg::MODE_WATCHDOG);
	assign it_ovf = ovf && (s_reg.mode == watchdog_pkg::MODE_INTERVAL) && s_reg.int_en;

	always_comb begin
		s_next       = s_reg;
		s_next.rdata = 8'h00;
		if (s_reg.run && tick) begin
			s_next.count = s_reg.count + 8'h01;
		end
		if (count_load) begin
			s_next.count = reg_wdata;
		end
		if (wr_first) begin
			s_next.write_en = reg_wdata[watchdog_pkg::FIRST_WRITE_ENABLE];
			// run bit moves only with the enable already set: a stray write cannot stop it
			if (s_reg.write_en && !reg_wdata[watchdog_pkg::FIRST_RUN_INHIBIT]) begin
				s_next.run = reg_wdata[watchdog_pkg::FIRST_RUN_BIT];
			end
			if (s_reg.write_en && !reg_wdata[watchdog_pkg::FIRST_OVERFLOW_FLAG]) begin
				s_next.ovf_flag = 1'b0;
			end
		end
		if (wr_second) begin
			if (s_reg.mode_armed) begin
				s_next.mode       = reg_wdata[watchdog_pkg::SECOND_MODE_SELECT];
				s_next.int_en     = reg_wdata[watchdog_pkg::SECOND_INT_ENABLE];
				s_next.mode_armed = 1'b0;
			end else if (!reg_wdata[watchdog_pkg::SECOND_MODE_INHIBIT]) begin
				s_next.mode_armed = 1'b1;
			end
		end
		if (reg_wr && (reg_addr == watchdog_pkg::OFS_CLOCK_SELECT)) begin
			s_next.clk_sel = reg_wdata[2:0];
		end
		if (reg_wr && (reg_addr == watchdog_pkg::OFS_IRQ_MASK)) begin
			s_next.irq_mask = reg_wdata[1:0];
		end
		if (reg_rd) begin
			unique case (reg_addr)
				watchdog_pkg::OFS_CTRL_STATUS_FIRST: begin
					s_next.rdata = {4'h0, s_reg.ovf_flag, s_reg.write_en, 1'b0, s_reg.run};
				end
				watchdog_pkg::OFS_CTRL_STATUS_SECOND: begin
					s_next.rdata = {5'h00, s_reg.int_en, !s_reg.mode_armed, s_reg.mode};
				end
				watchdog_pkg::OFS_UP_COUNTER: begin
					s_next.rdata = s_reg.count;
				end
				watchdog_pkg::OFS_CLOCK_SELECT: begin
					s_next.rdata = {5'h00, s_reg.clk_sel};
				end
				watchdog_pkg::OFS_IRQ_STATUS: begin
					s_next.rdata      = {6'h00, s_reg.irq_status};
					s_next.irq_status = 2'h0;
				end
				watchdog_pkg::OFS_IRQ_MASK: begin
					s_next.rdata = {6'h00, s_reg.irq_mask};
				end
				default: begin
					s_next.rdata = 8'h00;
				end
			endcase
		end
		if (s_reg.rst_active) begin
			if (s_reg.rst_cnt == 16'h0000) begin
				s_next.rst_active = 1'b0;
			end else begin
				s_next.rst_cnt = s_reg.rst_cnt - 16'h0001;
			end
		end
		// events last so that a set beats a clear in the same cycle
		if (wd_ovf) begin
			s_next.ovf_flag                           = 1'b1;
			s_next.rst_active                         = 1'b1;
			s_next.rst_cnt                            = watchdog_pkg::RESET_LOAD;
			s_next.irq_status[watchdog_pkg::IRQ_WD_RESET] = 1'b1;
		end
		if (it_ovf) begin
			s_next.irq_status[watchdog_pkg::IRQ_INTERVAL] = 1'b1;
		end
		s_next.irq = |(s_next.irq_status & s_next.irq_mask);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg            <= '0;
			s_reg.count      <= watchdog_pkg::COUNTER_RESET;
			s_reg.mode       <= watchdog_pkg::MODE_WATCHDOG;
			s_reg.clk_sel    <= watchdog_pkg::CLKSEL_RESET;
			s_reg.irq_mask   <= watchdog_pkg::IRQ_MASK_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata     = s_reg.rdata;
	assign irq           = s_reg.irq;
	assign wdt_reset_out = s_reg.rst_active;

	// helper: length of the current reset pulse
	logic [15:0] pulse_len;
	// a fresh overflow restarts the pulse, so restart the count with it
	always_ff @(posedge clk) begin
		if (srst || !wdt_reset_out || wd_ovf) begin
			pulse_len <= 16'h0000;
		end else begin
			pulse_len <= pulse_len + 16'h0001;
		end
	end

	sequence s_start_write;
		wr_first && s_reg.write_en && reg_wdata[watchdog_pkg::FIRST_RUN_BIT]
			&& !reg_wdata[watchdog_pkg::FIRST_RUN_INHIBIT];
	endsequence

	sequence s_ovf_seen;
		wd_ovf ##1 (wdt_reset_out && s_reg.ovf_flag);
	endsequence

	property p_wd_reset;
		@(posedge clk) disable iff (srst) wd_ovf |-> s_ovf_seen;
	endproperty
	a_wd_reset: assert property (p_wd_reset) else $error("no reset after overflow");

	property p_reset_len;
		@(posedge clk) disable iff (srst) $fell(wdt_reset_out) |-> pulse_len == 16'h0200;
	endproperty
	a_reset_len: assert property (p_reset_len) else $error("reset pulse too short");

	property p_reset_ends;
		@(posedge clk) disable iff (srst)
			(wdt_reset_out && pulse_len == 16'h0200 && !$past(wd_ovf)) |-> !wdt_reset_out;
	endproperty
	a_reset_ends: assert property (p_reset_ends) else $error("reset pulse too long");

	property p_interval;
		@(posedge clk) disable iff (srst)
			it_ovf |=> s_reg.irq_status[watchdog_pkg::IRQ_INTERVAL] && !$rose(wdt_reset_out);
	endproperty
	a_interval: assert property (p_interval) else $error("interval overflow misbehaved");

	property p_hold;
		@(posedge clk) disable iff (srst)
			(!s_reg.run && !count_load) |=> $stable(s_reg.count);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");

	property p_start;
		@(posedge clk) disable iff (srst) s_start_write |=> s_reg.run;
	endproperty
	a_start: assert property (p_start) else $error("timer did not start");

	property p_no_start;
		@(posedge clk) disable iff (srst) (wr_first && !s_reg.write_en) |=> $stable(s_reg.run);
	endproperty
	a_no_start: assert property (p_no_start) else $error("run bit changed unprotected");

	property p_load;
		@(posedge clk) disable iff (srst) count_load |=> s_reg.count == $past(reg_wdata);
	endproperty
	a_load: assert property (p_load) else $error("counter load lost");

	property p_mode_two_writes;
		@(posedge clk) disable iff (srst)
			$changed(s_reg.mode) |-> $past(s_reg.mode_armed) && $past(wr_second);
	endproperty
	a_mode_two_writes: assert property (p_mode_two_writes) else $error("mode changed early");

	property p_slow_tick;
		@(posedge clk) disable iff (srst)
			(tick && s_reg.clk_sel == 3'h7 && $stable(s_reg.clk_sel)) |=> (!tick)[*8];
	endproperty
	a_slow_tick: assert property (p_slow_tick) else $error("divider tick too fast");

	// second register unlock: an arming write, then a loading write
	sequence s_arm_write;
		wr_second && !s_reg.mode_armed && !reg_wdata[watchdog_pkg::SECOND_MODE_INHIBIT];
	endsequence

	sequence s_load_write;
		wr_second && s_reg.mode_armed;
	endsequence

	property p_arm;
		@(posedge clk) disable iff (srst)
			s_arm_write |=> s_reg.mode_armed && $stable(s_reg.mode);
	endproperty
	a_arm: assert property (p_arm) else $error("mode write did not arm");

	property p_mode_load;
		@(posedge clk) disable iff (srst)
			s_load_write |=> !s_reg.mode_armed
				&& (s_reg.mode == $past(reg_wdata[watchdog_pkg::SECOND_MODE_SELECT]))
				&& (s_reg.int_en == $past(reg_wdata[watchdog_pkg::SECOND_INT_ENABLE]));
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode load lost");

	// a stray write with the inhibit set must leave mode and unlock alone
	property p_unarmed;
		@(posedge clk) disable iff (srst)
			(wr_second && !s_reg.mode_armed && reg_wdata[watchdog_pkg::SECOND_MODE_INHIBIT])
				|=> !s_reg.mode_armed && $stable(s_reg.mode) && $stable(s_reg.int_en);
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("unarmed write used");

	property p_count_step;
		@(posedge clk) disable iff (srst)
			(s_reg.run && tick && !count_load)
				|=> s_reg.count == $past(s_reg.count) + 8'h01;
	endproperty
	a_count_step: assert property (p_count_step) else $error("missed tick");

	// sticky until an enabled write to the first register
	property p_flag_hold;
		@(posedge clk) disable iff (srst)
			(s_reg.ovf_flag && !(wr_first && s_reg.write_en)) |=> s_reg.ovf_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("overflow flag lost");

	property p_it_quiet;
		@(posedge clk) disable iff (srst)
			(ovf && s_reg.mode == watchdog_pkg::MODE_INTERVAL) |=> !$rose(wdt_reset_out);
	endproperty
	a_it_quiet: assert property (p_it_quiet) else $error("interval reset");

	property p_rdata_idle;
		@(posedge clk) disable iff (srst) !reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data");

	// status read clears it unless an event lands in the same cycle
	property p_status_clear;
		@(posedge clk) disable iff (srst)
			(reg_rd && reg_addr == watchdog_pkg::OFS_IRQ_STATUS && !ovf)
				|=> s_reg.irq_status == 2'h0;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status kept");

	property p_irq_level;
		@(posedge clk) disable iff (srst) irq == |(s_reg.irq_status & s_reg.irq_mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

endmodule // watchdog_interval_timer

// file: verif/tb_watchdog_interval_timer.sv
`timescale 1ns/1ns
module tb_watchdog_interval_timer;
	localparam logic [3:0] A_FST = watchdog_pkg::OFS_CTRL_STATUS_FIRST;
	localparam logic [3:0] A_SND = watchdog_pkg::OFS_CTRL_STATUS_SECOND;
	localparam logic [3:0] A_CNT = watchdog_pkg::OFS_UP_COUNTER;
	localparam logic [3:0] A_SEL = watchdog_pkg::OFS_CLOCK_SELECT;
	localparam logic [3:0] A_STA = watchdog_pkg::OFS_IRQ_STATUS;
	localparam logic [3:0] A_MSK = watchdog_pkg::OFS_IRQ_MASK;
	logic        clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        irq;
	logic        wdt_reset_out;
	logic [7:0]  exp_q[$];
	logic [15:0] len_q[$];
	logic        sel_q[$];
	logic        pin_q[$];
	logic        rd_q = 1'b0;
	logic [15:0] hi_cnt = 16'h0000;
	logic [7:0]  lfsr = 8'h32;
	int          n_fail = 0;
	int          n_compared = 0;
	int          cycles = 0;

	watchdog_interval_timer DUT (
		.clk           (clk),
		.srst          (srst),
		.reg_addr      (reg_addr),
		.reg_wdata     (reg_wdata),
		.reg_wr        (reg_wr),
		.reg_rd        (reg_rd),
		.reg_rdata     (reg_rdata),
		.irq           (irq),
		.wdt_reset_out (wdt_reset_out)
	);

	always #5 clk = ~clk;

	task automatic finish_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_len(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	// bounded wait, sel 1 for irq, 0 for reset output
	task automatic wait_for(input logic sel, input int lim);
		int n;
		n = 0;
		while (n < lim && (sel ? irq : wdt_reset_out) !== 1'b1) begin
			@(posedge clk);
			n++;
		end
		if ((sel ? irq : wdt_reset_out) !== 1'b1)
			n_fail++;
	endtask

	// pin expectation, compared by the monitor at the next rising edge
	task automatic pin_chk(input logic sel, input logic e);
		@(negedge clk);
		sel_q.push_back(sel);
		pin_q.push_back(e);
	endtask

	function automatic logic [7:0] next_rand(input logic [7:0] l);
		return {l[6:0], l[7] ^ l[5] ^ l[4] ^ l[3]};
	endfunction

	// read data lands one cycle after the strobe; pulse length measured at its fall
	always @(posedge clk) begin
		rd_q <= reg_rd;
		if (rd_q)
			check_data(reg_rdata, exp_q.pop_front());
		if (pin_q.size() > 0)
			check_data({7'h00, sel_q.pop_front() ? irq : wdt_reset_out}, {7'h00, pin_q.pop_front()});
		if (wdt_reset_out === 1'b1)
			hi_cnt <= hi_cnt + 16'h0001;
		else if (hi_cnt != 16'h0000) begin
			check_len(hi_cnt, len_q.pop_front());
			hi_cnt <= 16'h0000;
		end
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd(A_CNT, 8'h00);
		rd(A_FST, 8'h00);
		rd(A_SND, 8'h02);
		rd(A_SEL, {5'h00, watchdog_pkg::CLKSEL_RESET});
		rd(A_MSK, 8'h00);
		wr(4'hF, 8'hFF);
		rd(4'hF, 8'h00);
		wr(A_CNT, 8'h55);
		rd(A_CNT, 8'h00);
		wr(A_FST, 8'h04);
		wr(A_FST, 8'h07);
		rd(A_FST, 8'h04);
		for (int i = 0; i < 4; i++) begin
			lfsr = next_rand(lfsr);
			wr(A_CNT, lfsr);
			rd(A_CNT, lfsr);
		end
		for (int k = 0; k < 8; k++) begin
			wr(A_SEL, 8'(k));
			rd(A_SEL, 8'(k));
		end
		// shortest divider keeps the watchdog run brief
		wr(A_SEL, 8'h00);
		wr(A_MSK, 8'h02);
		wr(A_CNT, 8'hFE);
		len_q.push_back(16'h0200);
		wr(A_FST, 8'h05);
		rd(A_FST, 8'h05);
		repeat (50) @(posedge clk);
		pin_chk(1'b0, 1'b0);
		wait_for(1'b0, 150);
		pin_chk(1'b0, 1'b1);
		rd(A_FST, 8'h0D);
		pin_chk(1'b1, 1'b1);
		rd(A_STA, 8'h02);
		repeat (2) @(posedge clk);
		pin_chk(1'b1, 1'b0);
		wr(A_FST, 8'h04);
		rd(A_FST, 8'h04);
		repeat (520) @(posedge clk);
		wr(A_SND, 8'h07);
		rd(A_SND, 8'h02);
		wr(A_SND, 8'h00);
		rd(A_SND, 8'h00);
		wr(A_SND, 8'h05);
		rd(A_SND, 8'h07);
		wr(A_MSK, 8'h00);
		wr(A_CNT, 8'hFF);
		wr(A_FST, 8'h05);
		repeat (140) @(posedge clk);
		pin_chk(1'b0, 1'b0);
		pin_chk(1'b1, 1'b0);
		wr(A_MSK, 8'h01);
		repeat (2) @(posedge clk);
		pin_chk(1'b1, 1'b1);
		rd(A_STA, 8'h01);
		wr(A_FST, 8'h04);
		wr(A_SEL, 8'h07);
		wr(A_CNT, 8'hFF);
		wr(A_FST, 8'h05);
		// prescaler may run free, so time the gap between two ticks
		wait_for(1'b1, 8300);
		rd(A_STA, 8'h01);
		wr(A_CNT, 8'hFF);
		repeat (8000) @(posedge clk);
		pin_chk(1'b1, 1'b0);
		wait_for(1'b1, 300);
		pin_chk(1'b1, 1'b1);
		repeat (2) @(posedge clk);
		finish_test();
	end
endmodule // tb_watchdog_interval_timer
